// File: rtl/mcr_pkg.sv
// constants and types for the modem configuration register bank
// Operation
// - timers tick seconds and 10 ms, factory values
// - test options: bit0 end, bit1 band
// - bits 7:6 pick scrambler and ones detector
// - first firmware release keeps test functions off
// - calling bits 7:5 pick five behaviours
// - guard tone bits 7:6, high band only
// - equaliser bit0 tells crystal frequency
// - bit1 set disables fixed compromise equalisers
// - bit2 enables auto equaliser, always in QAM
// - transmit gain 1.5 dB steps, 111 is 0 dB
// - transmit bits 5:3 give data and stop bits
// - transmit parity bits 7:6: odd, even, none
// - receive gain uses the transmit gain codes
// - receive bits 5:3 give data and parity
// - receive overspeed bits 7:6: 2.3, 1, none
// - standard bits 7:4 hold codes 0 to 9
// - twist bits 2:0 select eight twist levels
// - twist only effective from board state 2
package mcr_pkg;
   localparam int REG_COUNT = 12;
   localparam logic [5:0] OFS_TIMER_SEC = 6'h00;
   localparam logic [5:0] OFS_TIMER_10MS = 6'h04;
   localparam logic [5:0] OFS_RSVD_A = 6'h08;
   localparam logic [5:0] OFS_BIT_ERR_TEST = 6'h0c;
   localparam logic [5:0] OFS_CALLING = 6'h10;
   localparam logic [5:0] OFS_GUARD_TONE = 6'h14;
   localparam logic [5:0] OFS_EQ_XTAL = 6'h18;
   localparam logic [5:0] OFS_TX_FRAMING = 6'h1c;
   localparam logic [5:0] OFS_RX_FRAMING = 6'h20;
   localparam logic [5:0] OFS_STANDARD = 6'h24;
   localparam logic [5:0] OFS_TWIST = 6'h28;
   localparam logic [5:0] OFS_RSVD_B = 6'h2c;
   localparam logic [5:0] OFS_STATUS = 6'h30;
   localparam logic [7:0] RST_VALUES [REG_COUNT] = '{
      8'h1e, 8'h02, 8'h00, 8'hc1, 8'h00, 8'h00,
      8'h01, 8'hb0, 8'h30, 8'h00, 8'h00, 8'h00};
   localparam logic [31:0] RD_UNMAPPED = 32'h0000_0000;
   localparam logic [2:0] GAIN_ZERO_DB = 3'h7;
   localparam logic [3:0] STD_MAX = 4'h9;
   localparam logic [2:0] CALL_MIN_SET = 3'h4;
   localparam logic [1:0] SCR_ON_DET = 2'h3;
   localparam logic [1:0] SCR_ON_NODET = 2'h2;
   localparam logic [1:0] TONE_550 = 2'h3;
   localparam logic [1:0] TONE_1800 = 2'h2;
   localparam logic [1:0] PAR_NONE = 2'h2;
   localparam logic [1:0] OVS_NONE = 2'h2;
   localparam logic [3:0] BOARD_STATE_TWIST = 4'h2;
   localparam logic [3:0] FW_FIRST_RELEASE = 4'h1;
   localparam int TIMER_SEC_MS = 1000;
   localparam int TIMER_TICK_MS = 10;
   localparam int CLK_KHZ = 50000;
   localparam int CYC_PER_TICK = TIMER_TICK_MS * CLK_KHZ;

   typedef struct packed {
      logic testEnable;
      logic testTxEnd;
      logic testHighBand;
      logic scramblerOn;
      logic onesDetectOn;
      logic [2:0] callProfile;
      logic [1:0] guardTone;
      logic xtalAlt;
      logic fixedEqOn;
      logic autoEqOn;
      logic [2:0] txGain;
      logic [1:0] txDataBits;
      logic txTwoStop;
      logic [1:0] txParity;
      logic [2:0] rxGain;
      logic [1:0] rxDataBits;
      logic rxParity;
      logic [1:0] rxOverspeed;
      logic [3:0] standard;
      logic [2:0] twist;
      logic twistOn;
      logic secTick;
      logic tenMsTick;
   } mcr_cfg_t;
endpackage

// File: rtl/mcr_bank.sv
// modem configuration register bank with Avalon-MM slave
`timescale 1ns/100ps
module mcr_bank #(
   parameter int TICK_CYCLES = mcr_pkg::CYC_PER_TICK,
   parameter logic [3:0] FW_RELEASE = 4'h1,
   parameter logic [3:0] BOARD_STATE = 4'h2
) (
   input wire logic ref_clk,
   input wire logic sys_rst,
   input wire logic [5:0] avsAddress,
   input wire logic avsRead,
   input wire logic avsWrite,
   input wire logic [31:0] avsWritedata,
   input wire logic [3:0] avsByteenable,
   input wire logic qamActive,
   input wire logic highBand,
   output logic [31:0] avsReaddata,
   output logic avsWaitrequest,
   output mcr_pkg::mcr_cfg_t cfg
);
   import mcr_pkg::*;

   logic [7:0] regs_r [REG_COUNT];
   logic waitReq_r;
   logic [31:0] rdData_r;
   logic [31:0] tickCnt_r;
   logic [6:0] secCnt_r;
   logic secTick_r;
   logic tenMsTick_r;
   mcr_cfg_t cfg_r;
   mcr_cfg_t cfg_nxt;

   wire logic request = (avsRead | avsWrite) & waitReq_r;
   wire logic [3:0] regIdx = avsAddress[5:2];
   wire logic hitBank = (avsAddress[1:0] == 2'h0) && (regIdx < 4'(REG_COUNT));
   wire logic hitStatus = (avsAddress == OFS_STATUS);
   // the write lands at the edge where waitrequest is seen low
   wire logic wrLane0 = avsWrite & ~waitReq_r & avsByteenable[0] & hitBank;
   wire logic [7:0] rdByte = hitBank ? regs_r[regIdx] : 8'h00;
   wire logic [31:0] statusWord = {20'h0, cfg_r.twistOn, cfg_r.testEnable,
      FW_RELEASE, BOARD_STATE, 2'h0};
   wire logic [31:0] rdSel = hitBank ? {24'h0, rdByte} :
      hitStatus ? statusWord : RD_UNMAPPED;

   // one wait cycle, then the request completes
   always_ff @(posedge ref_clk) begin
      if (sys_rst) begin
         waitReq_r <= 1'b1;
         rdData_r <= 32'h0;
      end else begin
         waitReq_r <= ~request;
         rdData_r <= rdSel;
      end
   end
   assign avsWaitrequest = waitReq_r;
   assign avsReaddata = rdData_r;

   // every bit stored, reserved ones too
   genvar gi;
   generate
      for (gi = 0; gi < REG_COUNT; gi++) begin : g_reg
         always_ff @(posedge ref_clk) begin
            if (sys_rst) begin
               regs_r[gi] <= RST_VALUES[gi];
            end else if (wrLane0 && regIdx == 4'(gi)) begin
               regs_r[gi] <= avsWritedata[7:0];
            end
         end
      end
   endgenerate

   // firmware timing base: 10 ms tick and one second tick
   always_ff @(posedge ref_clk) begin
      if (sys_rst) begin
         tickCnt_r <= 32'h0;
         secCnt_r <= 7'h0;
         tenMsTick_r <= 1'b0;
         secTick_r <= 1'b0;
      end else begin
         tenMsTick_r <= (tickCnt_r == 32'(TICK_CYCLES - 1));
         secTick_r <= 1'b0;
         if (tickCnt_r == 32'(TICK_CYCLES - 1)) begin
            tickCnt_r <= 32'h0;
            if (secCnt_r == 7'(TIMER_SEC_MS / TIMER_TICK_MS - 1)) begin
               secCnt_r <= 7'h0;
               secTick_r <= 1'b1;
            end else begin
               secCnt_r <= secCnt_r + 7'h1;
            end
         end else begin
            tickCnt_r <= tickCnt_r + 32'h1;
         end
      end
   end

   wire logic [7:0] rBet = regs_r[3];
   wire logic [7:0] rCall = regs_r[4];
   wire logic [7:0] rTone = regs_r[5];
   wire logic [7:0] rEq = regs_r[6];
   wire logic [7:0] rTx = regs_r[7];
   wire logic [7:0] rRx = regs_r[8];
   wire logic [7:0] rStd = regs_r[9];
   wire logic [7:0] rTw = regs_r[10];
   wire logic testOn = (FW_RELEASE != FW_FIRST_RELEASE);
   wire logic twistOk = (BOARD_STATE >= BOARD_STATE_TWIST);

   always_comb begin
      cfg_nxt = '0;
      cfg_nxt.testEnable = testOn;
      cfg_nxt.testTxEnd = testOn & rBet[0];
      cfg_nxt.testHighBand = testOn & rBet[1];
      cfg_nxt.scramblerOn = testOn && (rBet[7:6] == SCR_ON_DET ||
         rBet[7:6] == SCR_ON_NODET);
      cfg_nxt.onesDetectOn = testOn && (rBet[7:6] == SCR_ON_DET);
      // unlisted codes fall back to the basic profile
      cfg_nxt.callProfile = (rCall[7:5] >= CALL_MIN_SET) ?
         {1'b0, rCall[6:5]} + 3'h1 : 3'h0;
      cfg_nxt.guardTone = highBand && (rTone[7:6] == TONE_550 ||
         rTone[7:6] == TONE_1800) ? rTone[7:6] : 2'h0;
      cfg_nxt.xtalAlt = rEq[0];
      cfg_nxt.fixedEqOn = ~rEq[1];
      cfg_nxt.autoEqOn = rEq[2] | qamActive;
      cfg_nxt.txGain = rTx[2:0];
      cfg_nxt.txDataBits = rTx[5:4];
      cfg_nxt.txTwoStop = rTx[3];
      cfg_nxt.txParity = (rTx[7:6] > PAR_NONE) ? PAR_NONE : rTx[7:6];
      cfg_nxt.rxGain = rRx[2:0];
      cfg_nxt.rxDataBits = rRx[5:4];
      cfg_nxt.rxParity = rRx[3];
      cfg_nxt.rxOverspeed = (rRx[7:6] > OVS_NONE) ? OVS_NONE :
         rRx[7:6];
      cfg_nxt.standard = (rStd[7:4] > STD_MAX) ? STD_MAX : rStd[7:4];
      cfg_nxt.twistOn = twistOk;
      cfg_nxt.twist = twistOk ? rTw[2:0] : 3'h0;
      cfg_nxt.secTick = secTick_r;
      cfg_nxt.tenMsTick = tenMsTick_r;
   end

   always_ff @(posedge ref_clk) begin
      if (sys_rst) begin
         cfg_r <= '0;
      end else begin
         cfg_r <= cfg_nxt;
      end
   end
   assign cfg = cfg_r;

   AST_WAIT_ONE: assert property (@(posedge ref_clk) disable iff (sys_rst)
      (avsRead || avsWrite) && avsWaitrequest |=> !avsWaitrequest)
      else $error("request not answered after one wait cycle");
   AST_WRITE_STORE: assert property (@(posedge ref_clk) disable iff (sys_rst)
      wrLane0 && regIdx == 4'h7 |=> regs_r[7] == $past(avsWritedata[7:0]))
      else $error("written value not stored");
   AST_TEST_OFF: assert property (@(posedge ref_clk) disable iff (sys_rst)
      FW_RELEASE == FW_FIRST_RELEASE |-> !cfg.scramblerOn && !cfg.testTxEnd)
      else $error("test functions active in first release");
   AST_SCRAMBLER: assert property (@(posedge ref_clk) disable iff (sys_rst)
      testOn && rBet[7:6] == 2'h0 |=> !cfg.scramblerOn)
      else $error("scrambler on with code 00");
   AST_AUTOEQ_QAM: assert property (@(posedge ref_clk) disable iff (sys_rst)
      qamActive |=> cfg.autoEqOn)
      else $error("auto equaliser off in qam");
   AST_FIXED_EQ: assert property (@(posedge ref_clk) disable iff (sys_rst)
      1'b1 |=> cfg.fixedEqOn == !$past(rEq[1]))
      else $error("fixed equaliser wrong polarity");
   AST_XTAL: assert property (@(posedge ref_clk) disable iff (sys_rst)
      1'b1 |=> cfg.xtalAlt == $past(rEq[0]))
      else $error("crystal select mismatch");
   AST_TX_GAIN: assert property (@(posedge ref_clk) disable iff (sys_rst)
      1'b1 |=> cfg.txGain == $past(rTx[2:0]) && cfg.rxGain == $past(rRx[2:0]))
      else $error("gain code mismatch");
   AST_STD_RANGE: assert property (@(posedge ref_clk) disable iff (sys_rst)
      cfg.standard <= STD_MAX)
      else $error("standard code out of range");
   AST_TWIST: assert property (@(posedge ref_clk) disable iff (sys_rst)
      !twistOk |-> cfg.twist == 3'h0)
      else $error("twist applied on early board");
   AST_GUARD: assert property (@(posedge ref_clk) disable iff (sys_rst)
      !highBand |=> cfg.guardTone == 2'h0)
      else $error("guard tone outside high band");
   AST_TICK: assert property (@(posedge ref_clk) disable iff (sys_rst)
      cfg.tenMsTick |=> !cfg.tenMsTick)
      else $error("tick longer than one cycle");
   AST_SEC_TICK: assert property (@(posedge ref_clk) disable iff (sys_rst)
      cfg.secTick |-> cfg.tenMsTick)
      else $error("second tick off the ten ms grid");
   AST_WAIT_IDLE: assert property (@(posedge ref_clk) disable iff (sys_rst)
      !avsRead && !avsWrite |=> avsWaitrequest)
      else $error("waitrequest low without a request");
   AST_WRITE_ACK: assert property (@(posedge ref_clk) disable iff (sys_rst)
      wrLane0 |-> !avsWaitrequest)
      else $error("write stored while waitrequest high");
   AST_NO_EARLY_WRITE: assert property (@(posedge ref_clk)
      disable iff (sys_rst)
      avsWrite && avsWaitrequest && hitBank && regIdx == 4'h7
      |=> regs_r[7] == $past(regs_r[7]))
      else $error("write landed before the answer edge");
   AST_RD_UPPER: assert property (@(posedge ref_clk) disable iff (sys_rst)
      !avsWaitrequest |-> avsReaddata[31:12] == 20'h0)
      else $error("upper read data bits not zero");
   AST_ONES_DET: assert property (@(posedge ref_clk) disable iff (sys_rst)
      cfg.onesDetectOn |-> cfg.scramblerOn)
      else $error("ones detector on without scrambler");
   AST_TEST_END: assert property (@(posedge ref_clk) disable iff (sys_rst)
      !cfg.testEnable |-> !cfg.testTxEnd && !cfg.testHighBand)
      else $error("test options active while tests off");
   AST_CALL_RANGE: assert property (@(posedge ref_clk) disable iff (sys_rst)
      cfg.callProfile <= 3'h4)
      else $error("calling profile out of range");
   AST_TONE_CODE: assert property (@(posedge ref_clk) disable iff (sys_rst)
      cfg.guardTone != 2'h1)
      else $error("guard tone code undefined");
   AST_TX_FRAME: assert property (@(posedge ref_clk) disable iff (sys_rst)
      1'b1 |=> cfg.txDataBits == $past(rTx[5:4]) &&
      cfg.txTwoStop == $past(rTx[3]))
      else $error("transmit format mismatch");
   AST_PARITY_CODE: assert property (@(posedge ref_clk) disable iff (sys_rst)
      cfg.txParity != 2'h3)
      else $error("transmit parity code undefined");
   AST_RX_FRAME: assert property (@(posedge ref_clk) disable iff (sys_rst)
      1'b1 |=> cfg.rxDataBits == $past(rRx[5:4]) &&
      cfg.rxParity == $past(rRx[3]))
      else $error("receive format mismatch");
   AST_OVS_CODE: assert property (@(posedge ref_clk) disable iff (sys_rst)
      cfg.rxOverspeed != 2'h3)
      else $error("overspeed code undefined");
   AST_TWIST_PASS: assert property (@(posedge ref_clk) disable iff (sys_rst)
      twistOk |=> cfg.twist == $past(rTw[2:0]))
      else $error("twist level mismatch");

   COV_WRITE: cover property (@(posedge ref_clk) wrLane0);
   COV_READ: cover property (@(posedge ref_clk)
      avsRead && !avsWaitrequest && hitBank);
   COV_UNMAPPED: cover property (@(posedge ref_clk)
      avsRead && !hitBank && !hitStatus);
   COV_QAM: cover property (@(posedge ref_clk) qamActive && !rEq[2]);
endmodule

// File: testbench/modem_config_registers_test.sv
// self-checking bench for the modem configuration register bank
`timescale 1ns/100ps
module modem_config_registers_test;
   import mcr_pkg::*;
   typedef struct packed {
      logic [5:0] addr;
      logic [7:0] data;
      logic [7:0] expv;
   } mcr_row_t;
   logic ref_clk = 1'b0;
   logic sys_rst = 1'b1;
   logic [5:0] avsAddress = 6'h00;
   logic avsRead = 1'b0;
   logic avsWrite = 1'b0;
   logic [31:0] avsWritedata = 32'h0;
   logic [3:0] avsByteenable = 4'hf;
   logic qamActive = 1'b0;
   logic highBand = 1'b0;
   logic [31:0] avsReaddata;
   logic avsWaitrequest;
   mcr_cfg_t cfg;
   logic [31:0] rd;
   int bad_count = 0;
   int total_checks = 0;
   int tens = 0;
   int secs = 0;
   // write value and expected readback; 0x34 is unmapped
   mcr_row_t rows [13] = '{
      '{6'h00, 8'hff, 8'hff}, '{6'h04, 8'h00, 8'h00}, '{6'h08, 8'hff, 8'hff},
      '{6'h0c, 8'h03, 8'h03}, '{6'h10, 8'he0, 8'he0}, '{6'h14, 8'hc0, 8'hc0},
      '{6'h18, 8'h06, 8'h06}, '{6'h1c, 8'h00, 8'h00}, '{6'h20, 8'hff, 8'hff},
      '{6'h24, 8'h90, 8'h90}, '{6'h28, 8'h07, 8'h07}, '{6'h2c, 8'ha5, 8'ha5},
      '{6'h34, 8'h5a, 8'h00}};

   always #10 ref_clk = ~ref_clk;

   mcr_bank #(.TICK_CYCLES(10), .FW_RELEASE(4'h1), .BOARD_STATE(4'h2)) i_dut (
      .ref_clk(ref_clk), .sys_rst(sys_rst), .avsAddress(avsAddress),
      .avsRead(avsRead), .avsWrite(avsWrite), .avsWritedata(avsWritedata),
      .avsByteenable(avsByteenable), .qamActive(qamActive),
      .highBand(highBand), .avsReaddata(avsReaddata),
      .avsWaitrequest(avsWaitrequest), .cfg(cfg));

   task automatic stop_test();
      $display("checks %0d mismatches %0d", total_checks, bad_count);
      if (bad_count == 0 && total_checks > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask

   task automatic chk(input string what, input logic [31:0] expv,
         input logic [31:0] got);
      total_checks++;
      if (got !== expv) begin
         bad_count++;
         $display("unexpected %s: expected %h seen %h", what, expv, got);
      end
   endtask

   // one Avalon transfer; holds the request until waitrequest is seen low
   task automatic bus(input logic wr, input logic [5:0] a, input logic [7:0] d,
         input logic [3:0] be, output logic [31:0] q);
      avsAddress <= a;
      avsWrite <= wr;
      avsRead <= !wr;
      avsWritedata <= {24'h0, d};
      avsByteenable <= be;
      @(posedge ref_clk);
      while (avsWaitrequest !== 1'b0) begin
         @(posedge ref_clk);
      end
      q = avsReaddata;
      avsRead <= 1'b0;
      avsWrite <= 1'b0;
      // two edges so the decoded config reflects the write
      @(posedge ref_clk);
      @(posedge ref_clk);
   endtask

   initial begin
      repeat (20000) @(posedge ref_clk);
      bad_count++;
      stop_test();
   end

   initial begin
      repeat (10) @(posedge ref_clk);
      sys_rst <= 1'b0;
      @(posedge ref_clk);
      for (int i = 0; i < REG_COUNT; i++) begin
         bus(1'b0, 6'(i * 4), 8'h00, 4'hf, rd);
         chk("reset value", {24'h0, RST_VALUES[i]}, rd);
      end
      foreach (rows[i]) begin
         bus(1'b1, rows[i].addr, rows[i].data, 4'hf, rd);
         bus(1'b0, rows[i].addr, 8'h00, 4'hf, rd);
         chk("readback", {24'h0, rows[i].expv}, rd);
      end
      chk("test off", 32'h0, 32'(cfg.testEnable));
      chk("test end band", 32'h0, {cfg.testTxEnd, cfg.testHighBand});
      chk("calling", 32'h4, 32'(cfg.callProfile));
      chk("tone low band", 32'h0, 32'(cfg.guardTone));
      chk("eq", 32'h1, {cfg.xtalAlt, cfg.fixedEqOn, cfg.autoEqOn});
      chk("tx frame", 32'h0, {cfg.txGain, cfg.txDataBits, cfg.txTwoStop});
      chk("tx parity", 32'h0, 32'(cfg.txParity));
      chk("rx frame", 32'h3f, {cfg.rxGain, cfg.rxDataBits, cfg.rxParity});
      chk("standard", 32'h9, 32'(cfg.standard));
      chk("twist", 32'hf, {cfg.twist, cfg.twistOn});
      bus(1'b0, OFS_STATUS, 8'h00, 4'hf, rd);
      chk("status", 32'h48, rd & 32'h3fc);
      highBand <= 1'b1;
      qamActive <= 1'b1;
      bus(1'b1, OFS_EQ_XTAL, 8'h01, 4'hf, rd);
      chk("tone high band", 32'h3, 32'(cfg.guardTone));
      chk("eq qam", 32'h7, {cfg.xtalAlt, cfg.fixedEqOn, cfg.autoEqOn});
      bus(1'b1, OFS_STANDARD, 8'ha0, 4'hf, rd);
      chk("standard clamp", 32'h9, 32'(cfg.standard));
      bus(1'b1, OFS_RX_FRAMING, 8'h40, 4'hf, rd);
      chk("overspeed", 32'h1, 32'(cfg.rxOverspeed));
      bus(1'b1, OFS_TX_FRAMING, 8'hb6, 4'hf, rd);
      chk("tx gain frame", 32'h36, {cfg.txGain, cfg.txDataBits,
         cfg.txTwoStop});
      chk("tx no parity", 32'h2, 32'(cfg.txParity));
      bus(1'b1, OFS_TIMER_SEC, 8'h11, 4'he, rd);
      bus(1'b0, OFS_TIMER_SEC, 8'h00, 4'hf, rd);
      chk("lane 0 off", 32'hff, rd);
      bus(1'b1, OFS_STATUS, 8'hff, 4'hf, rd);
      bus(1'b0, OFS_STATUS, 8'h00, 4'hf, rd);
      chk("status ro", 32'h48, rd & 32'h3fc);
      repeat (1000) begin
         @(posedge ref_clk);
         if (cfg.tenMsTick === 1'b1) tens++;
         if (cfg.secTick === 1'b1) secs++;
      end
      chk("ten ms ticks", 32'd100, 32'(tens));
      chk("second ticks", 32'd1, 32'(secs));
      sys_rst <= 1'b1;
      repeat (2) @(posedge ref_clk);
      sys_rst <= 1'b0;
      @(posedge ref_clk);
      bus(1'b0, OFS_TIMER_SEC, 8'h00, 4'hf, rd);
      chk("second reset", 32'h1e, rd);
      stop_test();
   end
endmodule
